// file: cmd_pin_source.sv
// Command pin source model: square wave with programmable high and low time
`timescale 1ns/1ps
module cmd_pin_source
	import refmap_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Waveform control
	input wire logic run_i,
	input wire logic [CNT_W-1:0] high_i,
	input wire logic [CNT_W-1:0] low_i,
	// Pin
	output logic pin_o
);
	logic [CNT_W-1:0] cnt_q;
	logic pin_q;
	assign pin_o = pin_q;
	// A stopped source leaves the pin low, which the block reads as zero input
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= CNT_RESET;
			pin_q <= 1'b0;
		end else if (!run_i) begin
			cnt_q <= CNT_RESET;
			pin_q <= 1'b0;
		end else if (cnt_q == (pin_q ? high_i : low_i) - 24'h000001) begin
			cnt_q <= CNT_RESET;
			pin_q <= ~pin_q;
		end else begin
			cnt_q <= cnt_q + 24'h000001;
		end
	end
endmodule // cmd_pin_source

// file: motor_reference_input_mapper.sv
// Command source selection, duty command and reference profile mapping
// What this block does
// - Loop select 0 runs speed loop, 1 runs current loop from the same reference.
// - Source select: 00 analog, 01 PWM duty, 10 register command, 11 frequency.
// - Analog: zero at standby entry or below, linear from exit to full scale, clamp.
// - PWM: accept 0 to 100% duty, zero below entry, linear from exit duty.
// - Input frequency range is selectable for the frequency source only, independent of output switching rate.
// - When PWM or frequency pin input goes to zero, wait sleep-entry time before stopping.
// - Register mode: host writes command register, duty follows its value.
// - Register mode: sleep after zero command for sleep time with pin low.
// - Register mode: standby when command at or below threshold and pin above exit.
// - Frequency: zero at entry or below, linear to maximum frequency, clamp beyond.
// - Profile select: 00 direct, 01 linear, 10 staircase, 11 forward-reverse.
// - Direct speed mode: reference equals duty times full-scale rotation rate.
// - Direct profile ignores duty moves smaller than the deadband.
// - Zero input stops the motor under every profile.
// - Profile levels scale as level over 255 of rate or current cap.
// - Linear: hold low level, interpolate through A to E and high point, hold.
// - Except in direct profile: below low cutout give low cutout level; above high cutout give high cutout level.
// - Staircase steps level by level at hold point and breakpoints A to E.
// - Forward-reverse flips direction when duty crosses breakpoint C.
// - Forward-reverse ignores the direction pin and direction input.
// - Forward-reverse holds level A from A to B, then idles until breakpoint D.
`timescale 1ns/1ps
module motor_reference_input_mapper
	import refmap_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Command pin: comparator level and sampled analog code
	input wire logic cmd_pin_i,
	input wire logic [DUTY_W-1:0] cmd_level_i,
	// Mode configuration
	input wire logic rate_loop_bypass_i,
	input wire logic [1:0] source_sel_i,
	input wire logic [1:0] profile_sel_i,
	input wire logic [1:0] input_range_sel_i,
	input wire logic dir_i,
	// Source thresholds
	input wire logic [DUTY_W-1:0] standby_entry_voltage_i,
	input wire logic [DUTY_W-1:0] standby_exit_voltage_i,
	input wire logic [DUTY_W-1:0] analog_full_scale_voltage_i,
	input wire logic [DUTY_W-1:0] doze_entry_voltage_i,
	input wire logic [DUTY_W-1:0] doze_exit_voltage_i,
	input wire logic [DUTY_W-1:0] standby_entry_duty_i,
	input wire logic [DUTY_W-1:0] standby_exit_duty_i,
	input wire logic [CNT_W-1:0] standby_entry_period_i,
	input wire logic [CNT_W-1:0] standby_exit_period_i,
	input wire logic [CNT_W-1:0] max_freq_period_i,
	input wire logic [DUTY_W-1:0] digital_cmd_i,
	input wire logic [DUTY_W-1:0] digital_standby_i,
	input wire logic [15:0] sleep_entry_time_i,
	// Profile configuration
	input wire logic [DUTY_W-1:0] command_deadband_i,
	input wire logic [15:0] full_scale_rate_i,
	input wire logic [15:0] phase_current_cap_i,
	input wire logic [DUTY_W-1:0] low_cutout_point_i,
	input wire logic [DUTY_W-1:0] low_resume_point_i,
	input wire logic [DUTY_W-1:0] low_hold_point_i,
	input wire logic [DUTY_W-1:0] high_hold_point_i,
	input wire logic [DUTY_W-1:0] high_resume_point_i,
	input wire logic [DUTY_W-1:0] high_cutout_point_i,
	input wire logic [DUTY_W-1:0] low_cutout_level_i,
	input wire logic [DUTY_W-1:0] low_hold_level_i,
	input wire logic [DUTY_W-1:0] high_hold_level_i,
	input wire logic [DUTY_W-1:0] high_cutout_level_i,
	input wire logic [5*DUTY_W-1:0] bp_points_i,
	input wire logic [5*DUTY_W-1:0] bp_levels_i,
	// Outputs
	output logic [DUTY_W-1:0] duty_cmd_o,
	output logic [REF_W-1:0] reference_o,
	output logic current_loop_o,
	output logic reverse_o,
	output logic motor_stop_o,
	output logic sleep_o,
	output logic standby_o
);
	logic pin_meta_q, pin_sync_q;
	logic [DUTY_W-1:0] lvl_meta_q, lvl_sync_q;
	logic [CNT_W-1:0] high_t, period_t, low_run;
	logic period_done, freq_load_q;
	logic [DUTY_W-1:0] analog_duty, pwm_duty_q, freq_duty_q, freq_duty_w, reg_duty;
	logic [DUTY_W-1:0] raw_duty, duty_q;
	logic [CNT_W+7:0] pwm_num;
	logic [CNT_W-1:0] inv_freq, freq_entry, freq_exit, freq_full, per_clip;
	logic [CNT_W+5:0] sleep_cycles, zero_cnt_q;
	logic zero_long;
	logic [DUTY_W-1:0] map_lvl, held_duty_q;
	logic low_cut_q, high_cut_q, reverse_q;
	logic [REF_W-1:0] ref_q;
	logic [DUTY_W-1:0] pa, pb, pc, pd, pe, la, lb, lc, ld, le;

	function automatic logic [DUTY_W-1:0] lerp(input logic [DUTY_W-1:0] x, input logic [DUTY_W-1:0] x0,
		input logic [DUTY_W-1:0] x1, input logic [DUTY_W-1:0] y0, input logic [DUTY_W-1:0] y1);
		logic [17:0] t;
		logic [17:0] span;
		t = 18'h00000;
		span = (x1 > x0) ? {10'h000, x1 - x0} : 18'h00001;
		if (y1 >= y0) begin
			t = ({10'h000, x - x0} * {10'h000, y1 - y0}) / span;
			lerp = y0 + t[DUTY_W-1:0];
		end else begin
			t = ({10'h000, x - x0} * {10'h000, y0 - y1}) / span;
			lerp = y0 - t[DUTY_W-1:0];
		end
	endfunction

	function automatic logic [REF_W-1:0] scale255(input logic [DUTY_W-1:0] lvl, input logic [15:0] full);
		logic [23:0] p;
		p = {16'h0000, lvl} * {8'h00, full};
		scale255 = 16'(p / 24'h0000FF);
	endfunction

	assign {pe, pd, pc, pb, pa} = bp_points_i;
	assign {le, ld, lc, lb, la} = bp_levels_i;

	// Pin and analog code arrive from outside the clock domain
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
			lvl_meta_q <= DUTY_RESET;
			lvl_sync_q <= DUTY_RESET;
		end else begin
			pin_meta_q <= cmd_pin_i;
			pin_sync_q <= pin_meta_q;
			lvl_meta_q <= cmd_level_i;
			lvl_sync_q <= lvl_meta_q;
		end
	end

	pulse_meter u_meter (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(pin_sync_q),
		.high_o(high_t),
		.period_o(period_t),
		.done_o(period_done),
		.low_run_o(low_run)
	);

	span_scaler #(.W(DUTY_W)) u_analog (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.value_i(lvl_sync_q),
		.enter_i(standby_entry_voltage_i),
		.exit_i(standby_exit_voltage_i),
		.full_i(analog_full_scale_voltage_i),
		.duty_o(analog_duty)
	);

	// Frequency compared as inverse period; range select shifts the period scale
	assign per_clip = (period_t == CNT_RESET) ? ~CNT_RESET : (period_t >> input_range_sel_i);
	assign inv_freq = ~per_clip;
	assign freq_entry = ~(standby_entry_period_i >> input_range_sel_i);
	assign freq_exit = ~(standby_exit_period_i >> input_range_sel_i);
	assign freq_full = ~(max_freq_period_i >> input_range_sel_i);

	span_scaler #(.W(CNT_W)) u_freq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.value_i(inv_freq),
		.enter_i(freq_entry),
		.exit_i(freq_exit),
		.full_i(freq_full),
		.duty_o(freq_duty_w)
	);

	assign pwm_num = ({8'h00, high_t} * {{CNT_W{1'b0}}, DUTY_FULL}) / {8'h00, (period_t == CNT_RESET) ? 24'h000001 : period_t};

	// Duty refreshed once per completed input period
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pwm_duty_q <= DUTY_RESET;
		end else if (zero_long) begin
			pwm_duty_q <= DUTY_RESET;
		end else if (period_done) begin
			if (pwm_num[DUTY_W-1:0] <= standby_entry_duty_i || pwm_num[DUTY_W-1:0] < standby_exit_duty_i) begin
				pwm_duty_q <= DUTY_RESET;
			end else begin
				pwm_duty_q <= pwm_num[DUTY_W-1:0];
			end
		end
	end

	// Scaler output is registered, so load it one cycle after the period lands
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			freq_load_q <= 1'b0;
			freq_duty_q <= DUTY_RESET;
		end else begin
			freq_load_q <= period_done;
			if (zero_long) begin
				freq_duty_q <= DUTY_RESET;
			end else if (freq_load_q) begin
				freq_duty_q <= freq_duty_w;
			end
		end
	end

	assign reg_duty = (digital_cmd_i <= digital_standby_i) ? DUTY_RESET : digital_cmd_i;

	always_comb begin
		raw_duty = analog_duty;
		if (source_sel_i == SRC_PWM) begin
			raw_duty = pwm_duty_q;
		end else if (source_sel_i == SRC_I2C) begin
			raw_duty = sleep_o ? DUTY_RESET : reg_duty;
		end else if (source_sel_i == SRC_FREQ) begin
			raw_duty = freq_duty_q;
		end
	end

	// Zero-input timer; a low pin longer than sleep time ends pulse-based command
	assign sleep_cycles = {14'h0000, sleep_entry_time_i} * SLEEP_UNIT_CYCLES[15:0];
	assign zero_long = ({6'h00, low_run} >= sleep_cycles) && (source_sel_i != SRC_I2C);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			zero_cnt_q <= {(CNT_W+6){1'b0}};
		end else if (digital_cmd_i != DUTY_RESET) begin
			zero_cnt_q <= {(CNT_W+6){1'b0}};
		end else if (zero_cnt_q <= sleep_cycles) begin
			zero_cnt_q <= zero_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sleep_o <= 1'b0;
		end else if (source_sel_i != SRC_I2C) begin
			sleep_o <= 1'b0;
		end else if (lvl_sync_q > doze_exit_voltage_i) begin
			sleep_o <= 1'b0;
		end else if (zero_cnt_q > sleep_cycles && lvl_sync_q < doze_entry_voltage_i) begin
			sleep_o <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			standby_o <= 1'b0;
		end else begin
			standby_o <= (source_sel_i == SRC_I2C) && (digital_cmd_i <= digital_standby_i)
				&& (lvl_sync_q > doze_exit_voltage_i);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			duty_q <= DUTY_RESET;
		end else begin
			duty_q <= raw_duty;
		end
	end
	assign duty_cmd_o = duty_q;

	// Cutout hysteresis on both ends
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			low_cut_q <= 1'b1;
			high_cut_q <= 1'b0;
		end else begin
			if (duty_q < low_cutout_point_i) begin
				low_cut_q <= 1'b1;
			end else if (duty_q >= low_resume_point_i) begin
				low_cut_q <= 1'b0;
			end
			if (duty_q > high_cutout_point_i) begin
				high_cut_q <= 1'b1;
			end else if (duty_q <= high_resume_point_i) begin
				high_cut_q <= 1'b0;
			end
		end
	end

	// Forward-reverse direction flips at breakpoint C
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			reverse_q <= 1'b0;
		end else if (profile_sel_i == PROF_FWDREV) begin
			reverse_q <= (duty_q >= pc);
		end else begin
			reverse_q <= dir_i;
		end
	end

	always_comb begin
		map_lvl = low_hold_level_i;
		if (low_cut_q) begin
			map_lvl = low_cutout_level_i;
		end else if (high_cut_q) begin
			map_lvl = high_cutout_level_i;
		end else if (profile_sel_i == PROF_FWDREV) begin
			if (duty_q <= low_hold_point_i) map_lvl = low_hold_level_i;
			else if (duty_q < pa) map_lvl = lerp(duty_q, low_hold_point_i, pa, low_hold_level_i, la);
			else if (duty_q <= pb) map_lvl = la;
			else if (duty_q < pd) map_lvl = DUTY_RESET;
			else if (duty_q <= pe) map_lvl = ld;
			else if (duty_q < high_hold_point_i) map_lvl = lerp(duty_q, pe, high_hold_point_i, ld, high_hold_level_i);
			else map_lvl = high_hold_level_i;
		end else if (profile_sel_i == PROF_STAIR) begin
			if (duty_q < low_hold_point_i) map_lvl = low_hold_level_i;
			else if (duty_q < pa) map_lvl = la;
			else if (duty_q < pb) map_lvl = lb;
			else if (duty_q < pc) map_lvl = lc;
			else if (duty_q < pd) map_lvl = ld;
			else if (duty_q < pe) map_lvl = le;
			else map_lvl = high_hold_level_i;
		end else begin
			if (duty_q <= low_hold_point_i) map_lvl = low_hold_level_i;
			else if (duty_q < pa) map_lvl = lerp(duty_q, low_hold_point_i, pa, low_hold_level_i, la);
			else if (duty_q < pb) map_lvl = lerp(duty_q, pa, pb, la, lb);
			else if (duty_q < pc) map_lvl = lerp(duty_q, pb, pc, lb, lc);
			else if (duty_q < pd) map_lvl = lerp(duty_q, pc, pd, lc, ld);
			else if (duty_q < pe) map_lvl = lerp(duty_q, pd, pe, ld, le);
			else if (duty_q < high_hold_point_i) map_lvl = lerp(duty_q, pe, high_hold_point_i, le, high_hold_level_i);
			else map_lvl = high_hold_level_i;
		end
	end

	// Deadband memory for the direct profile
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			held_duty_q <= DUTY_RESET;
		end else if (duty_q == DUTY_RESET) begin
			held_duty_q <= DUTY_RESET;
		end else if (((duty_q > held_duty_q) ? duty_q - held_duty_q : held_duty_q - duty_q) >= command_deadband_i) begin
			held_duty_q <= duty_q;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ref_q <= REF_RESET;
		end else if (duty_q == DUTY_RESET) begin
			ref_q <= REF_RESET;
		end else if (profile_sel_i == PROF_DIRECT) begin
			ref_q <= scale255(held_duty_q, rate_loop_bypass_i ? phase_current_cap_i : full_scale_rate_i);
		end else begin
			ref_q <= scale255(map_lvl, rate_loop_bypass_i ? phase_current_cap_i : full_scale_rate_i);
		end
	end

	assign reference_o = ref_q;
	assign current_loop_o = rate_loop_bypass_i;
	assign reverse_o = reverse_q;
	assign motor_stop_o = (ref_q == REF_RESET);

	a_zero_stops: assert property (@(posedge clk_i) disable iff (rst_i)
		duty_q == DUTY_RESET |=> ref_q == REF_RESET) else $error("zero duty did not clear reference");
	a_fr_dir: assert property (@(posedge clk_i) disable iff (rst_i)
		profile_sel_i == PROF_FWDREV && duty_q >= pc |=> reverse_q) else $error("direction not reversed at C");
	a_stby_i2c: assert property (@(posedge clk_i) disable iff (rst_i)
		source_sel_i == SRC_I2C && digital_cmd_i <= digital_standby_i && lvl_sync_q > doze_exit_voltage_i
		|=> standby_o) else $error("standby missing");
	a_low_cut: assert property (@(posedge clk_i) disable iff (rst_i)
		duty_q < low_cutout_point_i |=> low_cut_q) else $error("low cutout not entered");
	a_sel_pwm: assert property (@(posedge clk_i) disable iff (rst_i)
		source_sel_i == SRC_PWM && $stable(source_sel_i) |=> duty_q == $past(pwm_duty_q)) else $error("pwm source not used");
	a_loop_sel: assert property (@(posedge clk_i) disable iff (rst_i)
		current_loop_o == rate_loop_bypass_i) else $error("loop select mismatch");
	a_sleep_exit: assert property (@(posedge clk_i) disable iff (rst_i)
		lvl_sync_q > doze_exit_voltage_i |=> !sleep_o) else $error("sleep not left");
	a_pwm_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		period_done && pwm_num[DUTY_W-1:0] <= standby_entry_duty_i && !zero_long |=> pwm_duty_q == DUTY_RESET)
		else $error("pwm standby duty nonzero");
endmodule // motor_reference_input_mapper

// file: motor_reference_input_mapper_test.sv
// Self-checking testbench for the motor reference input mapper
`timescale 1ns/1ps
module motor_reference_input_mapper_test
	import refmap_pkg::*;
;
	logic clk_i, rst_i, cmd_pin_i, rate_loop_bypass_i, dir_i, run;
	logic [1:0] source_sel_i, profile_sel_i, input_range_sel_i;
	logic [7:0] cmd_level_i, standby_entry_voltage_i, standby_exit_voltage_i, analog_full_scale_voltage_i;
	logic [7:0] doze_entry_voltage_i, doze_exit_voltage_i, standby_entry_duty_i, standby_exit_duty_i;
	logic [7:0] digital_cmd_i, digital_standby_i, command_deadband_i, low_cutout_point_i, low_resume_point_i;
	logic [7:0] low_hold_point_i, high_hold_point_i, high_resume_point_i, high_cutout_point_i;
	logic [7:0] low_cutout_level_i, low_hold_level_i, high_hold_level_i, high_cutout_level_i, duty_cmd_o;
	logic [23:0] standby_entry_period_i, standby_exit_period_i, max_freq_period_i, high_t, low_t;
	logic [15:0] sleep_entry_time_i, full_scale_rate_i, phase_current_cap_i, reference_o;
	logic [39:0] bp_points_i, bp_levels_i;
	logic current_loop_o, reverse_o, motor_stop_o, sleep_o, standby_o;
	int errors = 0;
	int n_checks = 0;

	motor_reference_input_mapper i_motor_reference_input_mapper (.clk_i, .rst_i, .cmd_pin_i, .cmd_level_i,
		.rate_loop_bypass_i, .source_sel_i, .profile_sel_i, .input_range_sel_i, .dir_i,
		.standby_entry_voltage_i, .standby_exit_voltage_i, .analog_full_scale_voltage_i,
		.doze_entry_voltage_i, .doze_exit_voltage_i, .standby_entry_duty_i, .standby_exit_duty_i,
		.standby_entry_period_i, .standby_exit_period_i, .max_freq_period_i, .digital_cmd_i,
		.digital_standby_i, .sleep_entry_time_i, .command_deadband_i, .full_scale_rate_i,
		.phase_current_cap_i, .low_cutout_point_i, .low_resume_point_i, .low_hold_point_i,
		.high_hold_point_i, .high_resume_point_i, .high_cutout_point_i, .low_cutout_level_i,
		.low_hold_level_i, .high_hold_level_i, .high_cutout_level_i, .bp_points_i, .bp_levels_i,
		.duty_cmd_o, .reference_o, .current_loop_o, .reverse_o, .motor_stop_o, .sleep_o, .standby_o);

	cmd_pin_source i_cmd_pin_source (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .high_i(high_t),
		.low_i(low_t), .pin_o(cmd_pin_i));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic fail(input logic [15:0] got, input logic [15:0] exp);
		errors++;
		$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
			fail({8'h00, got}, {8'h00, exp});
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
			fail(got, exp);
	endtask

	task automatic chk1(input logic got, input logic exp);
		n_checks++;
		if (got !== exp)
			fail({15'h0000, got}, {15'h0000, exp});
	endtask

	// Measured duty carries a rounding step, so a small window is allowed
	task automatic chk_near(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if ((^got === 1'bx) || (got > exp + 8'h02) || (got + 8'h02 < exp))
			fail({8'h00, got}, {8'h00, exp});
	endtask

	task automatic put_cmd(input logic [7:0] v);
		@(posedge clk_i);
		digital_cmd_i <= v;
		tick(10);
	endtask

	task automatic put_level(input logic [7:0] v);
		@(posedge clk_i);
		cmd_level_i <= v;
		tick(12);
	endtask

	// Full-scale rate of 255 makes the reference equal the profile level
	task automatic prof(input logic [7:0] d, input logic [7:0] lvl);
		put_cmd(d);
		chk16(reference_o, {8'h00, lvl});
	endtask

	task automatic wave(input logic [23:0] h, input logic [23:0] l, input int n);
		@(posedge clk_i);
		high_t <= h;
		low_t <= l;
		run <= 1'b1;
		tick(n);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		#200us;
		errors++;
		tally_and_finish();
	end

	initial begin
		rst_i = 1'b1;
		run = 1'b0;
		high_t = 24'h000001;
		low_t = 24'h000001;
		cmd_level_i = 8'hC8;
		rate_loop_bypass_i = 1'b0;
		dir_i = 1'b0;
		source_sel_i = SRC_I2C;
		profile_sel_i = PROF_DIRECT;
		input_range_sel_i = 2'h0;
		standby_entry_voltage_i = 8'h14;
		standby_exit_voltage_i = 8'h1E;
		analog_full_scale_voltage_i = 8'hC8;
		doze_entry_voltage_i = 8'h1E;
		doze_exit_voltage_i = 8'h32;
		standby_entry_duty_i = 8'h00;
		standby_exit_duty_i = 8'h00;
		standby_entry_period_i = 24'h0007D0;
		standby_exit_period_i = 24'h000708;
		max_freq_period_i = 24'h000064;
		digital_cmd_i = 8'h00;
		digital_standby_i = 8'h00;
		sleep_entry_time_i = 16'h0002;
		command_deadband_i = 8'h0A;
		full_scale_rate_i = 16'h00FF;
		phase_current_cap_i = 16'h01FE;
		low_cutout_point_i = 8'h0A;
		low_resume_point_i = 8'h14;
		low_hold_point_i = 8'h1E;
		high_hold_point_i = 8'hC8;
		high_resume_point_i = 8'hDC;
		high_cutout_point_i = 8'hF0;
		bp_points_i = {8'hB4, 8'h96, 8'h78, 8'h5A, 8'h3C};
		bp_levels_i = {8'hBE, 8'hA0, 8'h82, 8'h64, 8'h46};
		low_cutout_level_i = 8'h05;
		low_hold_level_i = 8'h28;
		high_hold_level_i = 8'hD2;
		high_cutout_level_i = 8'h0F;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		put_cmd(8'h80);
		chk8(duty_cmd_o, 8'h80);
		chk16(reference_o, 16'h0080);
		chk1(motor_stop_o, 1'b0);
		put_cmd(8'h85);
		chk8(duty_cmd_o, 8'h85);
		chk16(reference_o, 16'h0080);
		prof(8'h8C, 8'h8C);
		@(posedge clk_i);
		rate_loop_bypass_i <= 1'b1;
		put_cmd(8'hC8);
		chk1(current_loop_o, 1'b1);
		chk16(reference_o, 16'h0190);
		@(posedge clk_i);
		rate_loop_bypass_i <= 1'b0;
		digital_standby_i <= 8'h14;
		put_cmd(8'h0F);
		chk8(duty_cmd_o, 8'h00);
		chk1(standby_o, 1'b1);
		chk1(motor_stop_o, 1'b1);
		put_cmd(8'h00);
		put_level(8'h0A);
		tick(190);
		chk1(sleep_o, 1'b0);
		tick(400);
		chk1(sleep_o, 1'b1);
		put_level(8'h3C);
		chk1(sleep_o, 1'b0);
		@(posedge clk_i);
		digital_standby_i <= 8'h00;
		profile_sel_i <= PROF_LINEAR;
		prof(8'h3C, 8'h46);
		prof(8'h4B, 8'h55);
		prof(8'hBE, 8'hC8);
		prof(8'h19, 8'h28);
		prof(8'h0F, 8'h28);
		prof(8'h05, 8'h05);
		prof(8'h0F, 8'h05);
		prof(8'hD2, 8'hD2);
		prof(8'hF5, 8'h0F);
		prof(8'hE6, 8'h0F);
		prof(8'h00, 8'h00);
		chk1(motor_stop_o, 1'b1);
		@(posedge clk_i);
		profile_sel_i <= PROF_STAIR;
		prof(8'h4B, 8'h64);
		prof(8'h19, 8'h28);
		prof(8'hBE, 8'hD2);
		@(posedge clk_i);
		profile_sel_i <= PROF_FWDREV;
		dir_i <= 1'b1;
		prof(8'h4B, 8'h46);
		chk1(reverse_o, 1'b0);
		prof(8'h64, 8'h00);
		prof(8'hA0, 8'hA0);
		chk1(reverse_o, 1'b1);
		@(posedge clk_i);
		dir_i <= 1'b0;
		prof(8'h4B, 8'h46);
		chk1(reverse_o, 1'b0);
		@(posedge clk_i);
		source_sel_i <= SRC_ANALOG;
		profile_sel_i <= PROF_DIRECT;
		put_level(8'h14);
		chk8(duty_cmd_o, 8'h00);
		put_level(8'hC8);
		chk8(duty_cmd_o, 8'hFF);
		put_level(8'hFA);
		chk8(duty_cmd_o, 8'hFF);
		@(posedge clk_i);
		source_sel_i <= SRC_PWM;
		standby_entry_duty_i <= 8'h14;
		standby_exit_duty_i <= 8'h19;
		wave(24'h00000A, 24'h0000BE, 800);
		chk8(duty_cmd_o, 8'h00);
		@(posedge clk_i);
		standby_entry_duty_i <= 8'h00;
		standby_exit_duty_i <= 8'h00;
		wave(24'h000096, 24'h000032, 800);
		chk_near(duty_cmd_o, 8'hBF);
		@(posedge clk_i);
		run <= 1'b0;
		tick(600);
		chk8(duty_cmd_o, 8'h00);
		chk1(motor_stop_o, 1'b1);
		@(posedge clk_i);
		source_sel_i <= SRC_FREQ;
		sleep_entry_time_i <= 16'h0014;
		wave(24'h000028, 24'h000028, 400);
		chk8(duty_cmd_o, 8'hFF);
		wave(24'h0005DC, 24'h0005DC, 10000);
		chk8(duty_cmd_o, 8'h00);
		tally_and_finish();
	end
endmodule // motor_reference_input_mapper_test

// file: pulse_meter.sv
// High time and period measurement of the synchronised command pin
`timescale 1ns/1ps
module pulse_meter
	import refmap_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Synchronised pin level
	input wire logic pin_i,
	// Measurements: high time and period update on each rising edge, low run counts each low cycle
	output logic [CNT_W-1:0] high_o,
	output logic [CNT_W-1:0] period_o,
	output logic done_o,
	output logic [CNT_W-1:0] low_run_o
);
	logic prev_q;
	logic [CNT_W-1:0] per_cnt_q;
	logic [CNT_W-1:0] hi_cnt_q;
	logic [CNT_W-1:0] all_ones;
	assign all_ones = ~CNT_RESET;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= pin_i;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			per_cnt_q <= CNT_RESET;
			hi_cnt_q <= CNT_RESET;
			high_o <= CNT_RESET;
			period_o <= CNT_RESET;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (pin_i && !prev_q) begin
				high_o <= hi_cnt_q;
				period_o <= per_cnt_q;
				done_o <= 1'b1;
				per_cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1};
				hi_cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1};
			end else begin
				if (per_cnt_q != all_ones) begin
					per_cnt_q <= per_cnt_q + 1'b1;
				end
				if (pin_i && hi_cnt_q != all_ones) begin
					hi_cnt_q <= hi_cnt_q + 1'b1;
				end
			end
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			low_run_o <= CNT_RESET;
		end else if (pin_i) begin
			low_run_o <= CNT_RESET;
		end else if (low_run_o != all_ones) begin
			low_run_o <= low_run_o + 1'b1;
		end
	end
endmodule // pulse_meter

// file: refmap_pkg.sv
// Shared constants and types for the motor reference input mapper
package refmap_pkg;
	localparam int DUTY_W = 8;
	localparam int REF_W = 16;
	localparam int CNT_W = 24;
	localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hFF;
	localparam logic [1:0] SRC_ANALOG = 2'h0;
	localparam logic [1:0] SRC_PWM = 2'h1;
	localparam logic [1:0] SRC_I2C = 2'h2;
	localparam logic [1:0] SRC_FREQ = 2'h3;
	localparam logic [1:0] PROF_DIRECT = 2'h0;
	localparam logic [1:0] PROF_LINEAR = 2'h1;
	localparam logic [1:0] PROF_STAIR = 2'h2;
	localparam logic [1:0] PROF_FWDREV = 2'h3;
	localparam int CLK_MHZ = 200;
	localparam int SLEEP_TIME_UNIT_US = 1;
	localparam int SLEEP_UNIT_CYCLES = SLEEP_TIME_UNIT_US * CLK_MHZ;
	localparam logic [CNT_W-1:0] CNT_RESET = 24'h000000;
	localparam logic [DUTY_W-1:0] DUTY_RESET = 8'h00;
	localparam logic [REF_W-1:0] REF_RESET = 16'h0000;
	typedef enum logic [1:0] {
		Z_HOLD,
		Z_CUTOUT,
		Z_RUN
	} zone_t;
endpackage

// file: span_scaler.sv
// Linear map of a value between two thresholds onto a duty command
`timescale 1ns/1ps
module span_scaler
	import refmap_pkg::*;
#(
	parameter int W = CNT_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Value and thresholds
	input wire logic [W-1:0] value_i,
	input wire logic [W-1:0] enter_i,
	input wire logic [W-1:0] exit_i,
	input wire logic [W-1:0] full_i,
	// Result
	output logic [DUTY_W-1:0] duty_o
);
	logic [DUTY_W-1:0] duty_d;
	logic [W+DUTY_W-1:0] num;
	logic [W-1:0] den;
	logic [W+DUTY_W-1:0] quo;
	always_comb begin
		num = {{DUTY_W{1'b0}}, value_i - exit_i} * {{W{1'b0}}, DUTY_FULL};
		den = (full_i > exit_i) ? (full_i - exit_i) : {{(W-1){1'b0}}, 1'b1};
		quo = num / {{DUTY_W{1'b0}}, den};
		if (value_i <= enter_i || value_i < exit_i) begin
			duty_d = DUTY_RESET;
		end else if (value_i >= full_i) begin
			duty_d = DUTY_FULL;
		end else if (quo > {{W{1'b0}}, DUTY_FULL}) begin
			duty_d = DUTY_FULL;
		end else begin
			duty_d = quo[DUTY_W-1:0];
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			duty_o <= DUTY_RESET;
		end else begin
			duty_o <= duty_d;
		end
	end
endmodule // span_scaler
